//--- core/fcd_cfg.svh
// constants for the fieldbus control word decoder
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH
`define FCD_CW_W 16
`define FCD_ADDR_W 16
`define FCD_INT_W 32
`define FCD_SIX_BASE 20'd400001
`define FCD_SIX_TOP 20'd465536
`define FCD_FIVE_BASE 20'd40001
`define FCD_FIVE_TOP 20'd49999
`define FCD_B_OFF1 0
`define FCD_B_OFF2 1
`define FCD_B_OFF3 2
`define FCD_B_INHIBIT 3
`define FCD_B_RAMP_OUT 4
`define FCD_B_RAMP_HOLD 5
`define FCD_B_RAMP_IN 6
`define FCD_B_RESET 7
`define FCD_B_JOG1 8
`define FCD_B_JOG2 9
`define FCD_B_REMOTE 10
`define FCD_B_LOC 11
`define FCD_B_USER_LO 12
`define FCD_B_USER_HI 15
`define FCD_REF_W 16
`endif

//--- core/fcd_pkg.sv
// types for the fieldbus control word decoder
package fcd_pkg;
  typedef enum logic [2:0] {
    FCD_SW_ON_INHIBITED,
    FCD_READY_TO_SWITCH_ON,
    FCD_READY_TO_OPERATE,
    FCD_OPERATION_INHIBITED,
    FCD_OPERATING,
    FCD_OFF1_ACTIVE,
    FCD_OFF2_ACTIVE,
    FCD_OFF3_ACTIVE
  } fcd_state_t;

  typedef struct packed {
    logic ramp_out_enable;
    logic ramp_accel_enable;
    logic ramp_in_enable;
    logic ramps_locked;
  } fcd_ramp_t;

  typedef struct packed {
    logic jog1;
    logic jog2;
    logic run_enable;
    logic location_b;
    logic [3:0] user_bits;
  } fcd_req_t;
endpackage

//--- core/fcd_decoder.sv
// control word decoder for the embedded fieldbus interface
`timescale 1ns/100ps
`include "fcd_cfg.svh"
module fcd_decoder
  import fcd_pkg::*;
#(
  parameter int CW_W = `FCD_CW_W,
  parameter int REF_W = `FCD_REF_W
) (
  input wire logic clk,
  input wire logic resetn,
  // register number translation
  input wire logic [19:0] reg_number,
  input wire logic reg_six_digit,
  input wire logic reg_is_32bit,
  output logic [`FCD_ADDR_W-1:0] reg_address,
  output logic reg_valid,
  // control word from the fieldbus
  input wire logic cw_write,
  input wire logic [CW_W-1:0] command_word,
  input wire logic [REF_W-1:0] reference,
  input wire logic pass_through_profile,
  input wire logic fault_active,
  input wire logic src_ramp_in_fb,
  input wire logic src_reset_fb,
  input wire logic src_jog1_fb,
  input wire logic src_jog2_fb,
  input wire logic src_run_enable_fb,
  input wire logic src_location_fb,
  input wire logic stop_done,
  output logic [`FCD_INT_W-1:0] internal_word,
  output logic [REF_W-1:0] reference_held,
  output fcd_state_t drive_state,
  output fcd_ramp_t ramp_ctrl,
  output fcd_req_t requests,
  output logic fault_reset,
  output logic fieldbus_control,
  output logic coast_stop,
  output logic quick_stop,
  output logic ramp_stop
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  // two flops release the async reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // ************************************************************
  // register number translation
  // ************************************************************
  // true when a register number lies inside one numbering window
  function automatic logic fcd_in_range(input logic [19:0] num, input logic [19:0] lo, input logic [19:0] hi);
    fcd_in_range = (num >= lo) && (num <= hi);
  endfunction

  // offset from the window base, cut to the sixteen address bits on purpose
  function automatic logic [`FCD_ADDR_W-1:0] fcd_offset(input logic [19:0] num, input logic [19:0] base);
    logic [19:0] diff;
    diff = num - base;
    fcd_offset = diff[`FCD_ADDR_W-1:0];
  endfunction

  logic [`FCD_ADDR_W-1:0] addr_d;
  logic valid_d;

  // decimal register number to sixteen bit address
  always_comb begin
    addr_d = '0;
    valid_d = 1'b0;
    // five-digit masters only ever see the lowest 9999 registers
    if (reg_six_digit) begin
      if (fcd_in_range(reg_number, `FCD_SIX_BASE, `FCD_SIX_TOP)) begin
        addr_d = fcd_offset(reg_number, `FCD_SIX_BASE);
        valid_d = 1'b1;
      end
    end else if (fcd_in_range(reg_number, `FCD_FIVE_BASE, `FCD_FIVE_TOP)) begin
      addr_d = fcd_offset(reg_number, `FCD_FIVE_BASE);
      valid_d = !reg_is_32bit;
    end
  end

  // registered translation result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_address <= '0;
      reg_valid <= 1'b0;
    end else begin
      reg_address <= addr_d;
      reg_valid <= valid_d;
    end
  end

  // ************************************************************
  // control word capture
  // ************************************************************
  logic [CW_W-1:0] cw_q;
  logic [REF_W-1:0] ref_q;
  logic reset_bit_q;
  logic locked_q;
  logic remote_q;
  logic cw_accept;

  // a converting write with bit10 clear is refused, even when it is all zero
  assign cw_accept = cw_write && (pass_through_profile || command_word[`FCD_B_REMOTE]);

  // accepted write: take word and reference
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cw_q <= '0;
      ref_q <= '0;
    end else if (cw_accept) begin
      cw_q <= command_word;
      ref_q <= reference;
    end
  end

  // bit10 clear: keeps last word; a zero word with zero reference also locks ramps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_q <= 1'b0;
      remote_q <= 1'b0;
    end else if (cw_accept) begin
      locked_q <= 1'b0;
      remote_q <= 1'b1;
    end else if (cw_write && command_word == '0 && reference == '0) begin
      locked_q <= 1'b1;
      remote_q <= 1'b1;
    end
  end

  // previous reset bit; a refused word must not fake an edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_bit_q <= 1'b0;
    end else if (cw_accept && !pass_through_profile) begin
      reset_bit_q <= command_word[`FCD_B_RESET];
    end
  end

  logic reset_edge;
  assign reset_edge = cw_accept && !pass_through_profile && src_reset_fb &&
                      command_word[`FCD_B_RESET] && !reset_bit_q;

  // ************************************************************
  // drive state machine
  // ************************************************************
  logic off1_n;
  logic off2_n;
  logic off3_n;
  logic enable_op;
  logic conv;
  fcd_state_t state_q;
  fcd_state_t state_d;

  assign conv = !pass_through_profile;
  assign off1_n = cw_q[`FCD_B_OFF1];
  assign off2_n = cw_q[`FCD_B_OFF2];
  assign off3_n = cw_q[`FCD_B_OFF3];
  assign enable_op = cw_q[`FCD_B_INHIBIT];

  // next state while a coast or quick stop is requested
  function automatic fcd_state_t fcd_stop_next(input fcd_state_t cur, input fcd_state_t stop_state, input logic done);
    if (cur == FCD_SW_ON_INHIBITED || (cur == stop_state && done)) begin
      fcd_stop_next = FCD_SW_ON_INHIBITED;
    end else begin
      fcd_stop_next = stop_state;
    end
  endfunction

  // next state; coast and quick stop win over ramp off
  always_comb begin
    state_d = state_q;
    if (!conv) begin
      state_d = state_q;
    end else if (!off2_n) begin
      state_d = fcd_stop_next(state_q, FCD_OFF2_ACTIVE, stop_done);
    end else if (!off3_n) begin
      state_d = fcd_stop_next(state_q, FCD_OFF3_ACTIVE, stop_done);
    end else begin
      case (state_q)
        FCD_SW_ON_INHIBITED: begin
          if (!off1_n && !fault_active) begin
            state_d = FCD_READY_TO_SWITCH_ON;
          end
        end
        FCD_READY_TO_SWITCH_ON: begin
          if (off1_n) begin
            state_d = FCD_READY_TO_OPERATE;
          end
        end
        FCD_READY_TO_OPERATE: begin
          if (!off1_n) begin
            state_d = FCD_READY_TO_SWITCH_ON;
          end else if (enable_op) begin
            state_d = FCD_OPERATING;
          end
        end
        FCD_OPERATION_INHIBITED: begin
          if (!off1_n) begin
            state_d = FCD_READY_TO_SWITCH_ON;
          end else if (enable_op) begin
            state_d = FCD_OPERATING;
          end
        end
        FCD_OPERATING: begin
          if (!off1_n) begin
            state_d = FCD_OFF1_ACTIVE;
          end else if (!enable_op) begin
            state_d = FCD_OPERATION_INHIBITED;
          end
        end
        FCD_OFF1_ACTIVE: begin
          if (off1_n) begin
            state_d = FCD_OPERATING;
          end else if (stop_done) begin
            state_d = FCD_READY_TO_SWITCH_ON;
          end
        end
        FCD_OFF2_ACTIVE, FCD_OFF3_ACTIVE: begin
          state_d = FCD_SW_ON_INHIBITED;
        end
        default: begin
          state_d = FCD_SW_ON_INHIBITED;
        end
      endcase
    end
    if (conv && reset_edge && fault_active) begin
      state_d = FCD_SW_ON_INHIBITED;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FCD_SW_ON_INHIBITED;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // decoded outputs
  // ************************************************************
  fcd_ramp_t ramp_d;
  fcd_req_t req_d;
  logic [`FCD_INT_W-1:0] iw_d;

  // ramp and request decode from held word
  always_comb begin
    ramp_d.ramp_out_enable = conv && cw_q[`FCD_B_RAMP_OUT] && !locked_q;
    ramp_d.ramp_accel_enable = conv && cw_q[`FCD_B_RAMP_HOLD] && !locked_q;
    ramp_d.ramp_in_enable = conv && (!src_ramp_in_fb || cw_q[`FCD_B_RAMP_IN]) && !locked_q;
    ramp_d.ramps_locked = locked_q;
    req_d.jog1 = conv && src_jog1_fb && cw_q[`FCD_B_JOG1];
    req_d.jog2 = conv && src_jog2_fb && cw_q[`FCD_B_JOG2];
    req_d.run_enable = conv && src_run_enable_fb && enable_op;
    req_d.location_b = conv && src_location_fb && cw_q[`FCD_B_LOC];
    req_d.user_bits = conv ? cw_q[`FCD_B_USER_HI:`FCD_B_USER_LO] : 4'h0;
    iw_d = '0;
    iw_d[CW_W-1:0] = cw_q;
  end

  // registered ramp and request outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_ctrl <= '0;
      requests <= '0;
    end else begin
      ramp_ctrl <= ramp_d;
      requests <= req_d;
    end
  end

  // registered word, reference and remote flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      internal_word <= '0;
      reference_held <= '0;
      fieldbus_control <= 1'b0;
    end else begin
      internal_word <= pass_through_profile ? iw_d : '0;
      reference_held <= ref_q;
      fieldbus_control <= remote_q;
    end
  end

  // one-cycle fault reset pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reset <= 1'b0;
    end else begin
      fault_reset <= reset_edge && fault_active;
    end
  end

  // stop levels follow state_d so they line up with drive_state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coast_stop <= 1'b0;
      quick_stop <= 1'b0;
      ramp_stop <= 1'b0;
      drive_state <= FCD_SW_ON_INHIBITED;
    end else begin
      coast_stop <= state_d == FCD_OFF2_ACTIVE;
      quick_stop <= state_d == FCD_OFF3_ACTIVE;
      ramp_stop <= state_d == FCD_OFF1_ACTIVE;
      drive_state <= state_d;
    end
  end

endmodule

//--- test/fcd_decoder_props.sv
// assertions on the decoder ports
`timescale 1ns/100ps
module fcd_decoder_props
  import fcd_pkg::*;
#(
  parameter int CW_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [19:0] reg_number,
  input wire logic reg_six_digit,
  input wire logic reg_is_32bit,
  input wire logic [15:0] reg_address,
  input wire logic reg_valid,
  input wire logic cw_write,
  input wire logic [CW_W-1:0] command_word,
  input wire logic pass_through_profile,
  input wire logic [31:0] internal_word,
  input wire fcd_state_t drive_state,
  input wire logic fault_reset,
  input wire logic coast_stop,
  input wire logic quick_stop,
  input wire logic ramp_stop
);
  logic [1:0] up_q;
  logic [19:0] d6;
  logic [19:0] d5;
  logic up;
  // cycles since release, covers the internal sync stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  assign up = (up_q == 2'h3);
  assign d6 = reg_number - 20'd400001;
  assign d5 = reg_number - 20'd40001;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_six_map: assert property (up && reg_six_digit && reg_number >= 20'd400001 &&
    reg_number <= 20'd465536 |=> reg_valid && reg_address == $past(d6[15:0])) else $error("six digit map");
  a_five_map: assert property (up && !reg_six_digit && !reg_is_32bit && reg_number >= 20'd40001 &&
    reg_number <= 20'd49999 |=> reg_valid && reg_address == $past(d5[15:0])) else $error("five digit map");
  a_five_wide: assert property (up && !reg_six_digit && reg_is_32bit |=> !reg_valid)
    else $error("wide param via five digit");
  a_fault_pulse: assert property (fault_reset |=> !fault_reset) else $error("fault reset too long");
  a_coast_level: assert property (up |-> coast_stop == (drive_state == FCD_OFF2_ACTIVE))
    else $error("coast stop level");
  a_quick_level: assert property (up |-> quick_stop == (drive_state == FCD_OFF3_ACTIVE))
    else $error("quick stop level");
  a_ramp_level: assert property (up |-> ramp_stop == (drive_state == FCD_OFF1_ACTIVE))
    else $error("ramp stop level");
  a_word_upper: assert property (up |-> internal_word[31:16] == 16'h0000) else $error("upper word used");
  a_pass_copy: assert property (up && cw_write && pass_through_profile ##1 !cw_write [*3]
    |-> internal_word[15:0] == $past(command_word, 3)) else $error("pass copy");
endmodule
bind fcd_decoder fcd_decoder_props #(.CW_W(CW_W)) u_fcd_decoder_props (.clk(clk), .resetn(resetn),
  .reg_number(reg_number), .reg_six_digit(reg_six_digit), .reg_is_32bit(reg_is_32bit),
  .reg_address(reg_address), .reg_valid(reg_valid), .cw_write(cw_write), .command_word(command_word),
  .pass_through_profile(pass_through_profile), .internal_word(internal_word), .drive_state(drive_state),
  .fault_reset(fault_reset), .coast_stop(coast_stop), .quick_stop(quick_stop), .ramp_stop(ramp_stop));

//--- test/fcd_master_model.sv
// fieldbus master model sending control words
`timescale 1ns/100ps
module fcd_master_model (
  input wire logic clk,
  output logic cw_write,
  output logic [15:0] command_word,
  output logic [15:0] reference
);
  initial begin
    cw_write = 1'b0;
    command_word = 16'h0000;
    reference = 16'h0000;
  end
  // one packed word per write, lines scrambled once released
  task automatic send(input logic [15:0] w, input logic [15:0] r);
    @(negedge clk);
    cw_write = 1'b1;
    command_word = w;
    reference = r;
    @(negedge clk);
    cw_write = 1'b0;
    command_word = ~w;
    reference = ~r;
  endtask
endmodule

//--- test/fcd_decoder_test.sv
// self-checking bench for the control word decoder
`timescale 1ns/100ps
module fcd_decoder_test
  import fcd_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [19:0] reg_number = 20'h0;
  logic reg_six_digit = 1'b0;
  logic reg_is_32bit = 1'b0;
  logic pt = 1'b0;
  logic fault_active = 1'b0;
  logic src = 1'b1;
  logic src_jog1 = 1'b1;
  logic stop_done = 1'b0;
  logic [15:0] rf = 16'h0100;
  logic cw_write;
  logic [15:0] command_word;
  logic [15:0] reference;
  logic [15:0] reg_address;
  logic reg_valid;
  logic [31:0] internal_word;
  logic [15:0] reference_held;
  fcd_state_t drive_state;
  fcd_ramp_t ramp_ctrl;
  fcd_req_t requests;
  logic fault_reset;
  logic fieldbus_control;
  logic coast_stop;
  logic quick_stop;
  logic ramp_stop;
  int errors = 0;
  int comparisons = 0;
  int pulses = 0;
  always #2 clk = ~clk;
  fcd_master_model u_fcd_master_model (.clk(clk), .cw_write(cw_write), .command_word(command_word),
    .reference(reference));
  fcd_decoder u_fcd_decoder (.clk(clk), .resetn(resetn), .reg_number(reg_number), .reg_six_digit(reg_six_digit),
    .reg_is_32bit(reg_is_32bit), .reg_address(reg_address), .reg_valid(reg_valid), .cw_write(cw_write),
    .command_word(command_word), .reference(reference), .pass_through_profile(pt),
    .fault_active(fault_active), .src_ramp_in_fb(src), .src_reset_fb(src), .src_jog1_fb(src_jog1),
    .src_jog2_fb(src), .src_run_enable_fb(src), .src_location_fb(src), .stop_done(stop_done),
    .internal_word(internal_word), .reference_held(reference_held), .drive_state(drive_state), .ramp_ctrl(ramp_ctrl),
    .requests(requests), .fault_reset(fault_reset), .fieldbus_control(fieldbus_control),
    .coast_stop(coast_stop), .quick_stop(quick_stop), .ramp_stop(ramp_stop));
  // count fault reset pulses
  always @(posedge clk) begin
    if (fault_reset === 1'b1) begin
      pulses++;
    end
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // register number translation, one cycle later
  task automatic tr(input logic six, input logic w32, input logic [19:0] n, input logic [15:0] a, input logic v);
    @(negedge clk);
    reg_six_digit = six;
    reg_is_32bit = w32;
    reg_number = n;
    @(negedge clk);
    chk("reg_valid", reg_valid, v);
    if (v) begin
      chk("reg_address", reg_address, a);
    end
  endtask
  // one control word, then let it settle
  task automatic wr(input logic [15:0] w);
    u_fcd_master_model.send(w, rf);
    repeat (4) @(negedge clk);
  endtask
  task automatic st(input fcd_state_t s);
    chk("drive_state", drive_state, s);
  endtask
  initial begin
    #40000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    st(FCD_SW_ON_INHIBITED);
    tr(1'b1, 1'b0, 20'd400001, 16'h0000, 1'b1);
    tr(1'b1, 1'b0, 20'd465536, 16'hffff, 1'b1);
    tr(1'b0, 1'b0, 20'd40001, 16'h0000, 1'b1);
    tr(1'b0, 1'b0, 20'd49999, 16'h270e, 1'b1);
    tr(1'b1, 1'b1, 20'd409999, 16'h270e, 1'b1);
    tr(1'b0, 1'b1, 20'd40001, 16'h0000, 1'b0);
    tr(1'b1, 1'b0, 20'd400000, 16'h0000, 1'b0);
    wr(16'h0406);
    st(FCD_READY_TO_SWITCH_ON);
    chk("fieldbus_control", fieldbus_control, 1'b1);
    chk("reference_held", reference_held, 16'h0100);
    wr(16'h0407);
    st(FCD_READY_TO_OPERATE);
    wr(16'hff7f);
    st(FCD_OPERATING);
    chk("ramp_ctrl", ramp_ctrl, 4'he);
    chk("requests", requests, 8'hff);
    src_jog1 = 1'b0;
    wr(16'h057f);
    chk("requests", requests, 8'h20);
    src_jog1 = 1'b1;
    wr(16'h047b);
    st(FCD_OFF3_ACTIVE);
    chk("quick_stop", quick_stop, 1'b1);
    stop_done = 1'b1;
    repeat (4) @(negedge clk);
    st(FCD_SW_ON_INHIBITED);
    stop_done = 1'b0;
    wr(16'h0406);
    wr(16'h0407);
    wr(16'h047f);
    wr(16'h047e);
    st(FCD_OFF1_ACTIVE);
    chk("ramp_stop", ramp_stop, 1'b1);
    stop_done = 1'b1;
    repeat (4) @(negedge clk);
    st(FCD_READY_TO_SWITCH_ON);
    stop_done = 1'b0;
    wr(16'h0407);
    wr(16'h047f);
    wr(16'h0478);
    st(FCD_OFF2_ACTIVE);
    chk("coast_stop", coast_stop, 1'b1);
    chk("quick_stop", quick_stop, 1'b0);
    chk("ramp_stop", ramp_stop, 1'b0);
    stop_done = 1'b1;
    repeat (4) @(negedge clk);
    st(FCD_SW_ON_INHIBITED);
    stop_done = 1'b0;
    fault_active = 1'b1;
    wr(16'h0406);
    pulses = 0;
    wr(16'h0486);
    chk("fault_reset pulses", pulses, 32'h1);
    st(FCD_SW_ON_INHIBITED);
    fault_active = 1'b0;
    wr(16'h0406);
    rf = 16'h0200;
    wr(16'h0007);
    st(FCD_READY_TO_SWITCH_ON);
    chk("reference_held", reference_held, 16'h0100);
    rf = 16'h0000;
    wr(16'h0000);
    chk("ramps_locked", ramp_ctrl.ramps_locked, 1'b1);
    pt = 1'b1;
    wr(16'h1234);
    chk("internal_word", internal_word, 32'h00001234);
    chk("requests", requests, 8'h00);
    chk("reference_held", reference_held, 16'h0000);
    report_and_stop();
  end
endmodule
